// File: hw/chan_flag.sv
`timescale 1ns/10ps
`include "tcf_cfg.svh"

module chan_flag (
    input wire logic clk,
    input wire logic rstn,
    input wire logic evt,
    input wire logic flag_rd,
    input wire logic flag_wr0,
    output logic flag,
    output logic armed
);
    import tcf_pkg::*;

    logic flag_r;
    logic flag_nxt;
    logic armed_r;
    logic armed_nxt;
    logic clr;

    // ************************************************************
    // two-step clear
    // ************************************************************
    always_comb begin
        // clear needs a read of the set flag in an earlier cycle
        clr = flag_wr0 & armed_r;
        // a new event beats a clear in the same cycle
        flag_nxt = evt | (flag_r & ~clr);
        armed_nxt = flag_nxt & ~clr & (armed_r | (flag_rd & flag_r));
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flag_r <= `TCF_BIT_RST;
            armed_r <= `TCF_BIT_RST;
        end else begin
            flag_r <= flag_nxt;
            armed_r <= armed_nxt;
        end
    end

    assign flag = flag_r;
    assign armed = armed_r;

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    no_blind_clear_a: assert property (
        flag_r && flag_wr0 && !armed_r |=> flag_r
    ) else $error("flag cleared without prior read");

    read_then_clear_a: assert property (
        flag_r && flag_rd ##1 (flag_wr0 && !evt && !flag_rd) |=> !flag_r
    ) else $error("two-step clear did not clear flag");

    clear_seen_c: cover property (flag_rd && flag_r ##1 flag_wr0 ##1 !flag_r);

endmodule

// File: hw/timer_channel_event_flags.sv
`timescale 1ns/10ps
`include "tcf_cfg.svh"

// What this block does
// - Each channel's event flag means what that channel's present mode says it means, except in center-aligned PWM, which overrides every channel's mode.
// - In capture mode a two-bit edge field picks rising, falling, both or no edge, none meaning no events.
// - In capture mode the flag is set when the chosen edge is seen on the channel pin.
// - In compare mode the flag is set every time the counter equals the 16-bit channel value.
// - In edge-aligned PWM the flag is set when the counter equals the channel value, ending the duty.
// - In center-aligned PWM the flag is set at both matches per period, duty start and duty end.
// - In center-aligned operation the step from the modulus down to the next lower count ends a period.
// - In center-aligned operation a count of zero marks the middle of the period.
module timer_channel_event_flags #(
    parameter int NCH = `TCF_NCH_DEF,
    parameter int CNT_W = `TCF_CNT_W
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic center_aligned_pwm,
    input wire logic [CNT_W-1:0] cnt,
    input wire logic cnt_step,
    input wire logic [CNT_W-1:0] modulus,
    input wire tcf_pkg::chan_mode_t [NCH-1:0] mode,
    input wire tcf_pkg::edge_sel_t [NCH-1:0] capture_edge_select,
    input wire logic [NCH-1:0][CNT_W-1:0] chan_val,
    input wire logic [NCH-1:0] chan_pin,
    input wire logic [NCH-1:0] flag_rd,
    input wire logic [NCH-1:0] flag_wr0,
    output logic [NCH-1:0] chan_flag,
    output logic [NCH-1:0] chan_evt,
    output logic period_end,
    output logic period_mid
);
    import tcf_pkg::*;

    if (NCH < 1 || NCH > `TCF_NCH_MAX) begin : g_bad_nch
        $error("NCH out of range");
    end
    if (CNT_W < 2) begin : g_bad_w
        $error("CNT_W too small");
    end

    // ************************************************************
    // pin synchronisers and edge history
    // ************************************************************
    logic [NCH-1:0] pin_meta_r;
    logic [NCH-1:0] pin_sync_r;
    logic [NCH-1:0] pin_prev_r;
    logic [NCH-1:0] pin_meta_nxt;
    logic [NCH-1:0] pin_sync_nxt;
    logic [NCH-1:0] pin_prev_nxt;

    always_comb begin
        pin_meta_nxt = chan_pin;
        pin_sync_nxt = pin_meta_r;
        pin_prev_nxt = pin_sync_r;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
            pin_prev_r <= '0;
        end else begin
            pin_meta_r <= pin_meta_nxt;
            pin_sync_r <= pin_sync_nxt;
            pin_prev_r <= pin_prev_nxt;
        end
    end

    // ************************************************************
    // period markers of the up/down count
    // ************************************************************
    logic [CNT_W-1:0] cnt_prev_r;
    logic [CNT_W-1:0] cnt_prev_nxt;
    logic end_r;
    logic end_nxt;
    logic mid_r;
    logic mid_nxt;
    logic [CNT_W-1:0] mod_dn;

    assign mod_dn = modulus - {{(CNT_W-1){1'b0}}, 1'b1};

    always_comb begin
        cnt_prev_nxt = cnt_step ? cnt : cnt_prev_r;
        // compare against the count before the step, so direction needs no input
        end_nxt = center_aligned_pwm & cnt_step & (cnt_prev_r == modulus)
                  & (cnt == mod_dn);
        mid_nxt = center_aligned_pwm & cnt_step & (cnt == '0);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_prev_r <= '0;
            end_r <= `TCF_BIT_RST;
            mid_r <= `TCF_BIT_RST;
        end else begin
            cnt_prev_r <= cnt_prev_nxt;
            end_r <= end_nxt;
            mid_r <= mid_nxt;
        end
    end

    assign period_end = end_r;
    assign period_mid = mid_r;

    // ************************************************************
    // per-channel event decode
    // ************************************************************
    logic [NCH-1:0] rise;
    logic [NCH-1:0] fall;
    logic [NCH-1:0] match;
    logic [NCH-1:0] cap_evt;
    logic [NCH-1:0] evt;
    logic [NCH-1:0] evt_r;
    logic [NCH-1:0] armed;

    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            rise[i] = pin_sync_r[i] & ~pin_prev_r[i];
            fall[i] = ~pin_sync_r[i] & pin_prev_r[i];
            // match counts once per counter step, not per held clock
            match[i] = cnt_step & (cnt == chan_val[i]);
            case (capture_edge_select[i])
                EDGE_RISE: cap_evt[i] = rise[i];
                EDGE_FALL: cap_evt[i] = fall[i];
                EDGE_BOTH: cap_evt[i] = rise[i] | fall[i];
                EDGE_NONE: cap_evt[i] = 1'b0;
                default: cap_evt[i] = 1'b0;
            endcase
            // center-aligned mode overrides the per-channel mode
            if (center_aligned_pwm) begin
                evt[i] = match[i];
            end else begin
                case (mode[i])
                    MODE_CAPTURE: evt[i] = cap_evt[i];
                    MODE_COMPARE: evt[i] = match[i];
                    MODE_EDGE_PWM: evt[i] = match[i];
                    default: evt[i] = 1'b0;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            evt_r <= '0;
        end else begin
            evt_r <= evt;
        end
    end

    assign chan_evt = evt_r;

    for (genvar g = 0; g < NCH; g++) begin : g_ch
        chan_flag u_flag (
            .clk(clk),
            .rstn(rstn),
            .evt(evt[g]),
            .flag_rd(flag_rd[g]),
            .flag_wr0(flag_wr0[g]),
            .flag(chan_flag[g]),
            .armed(armed[g])
        );
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    for (genvar a = 0; a < NCH; a++) begin : g_chk
        flag_cause_a: assert property (
            $rose(chan_flag[a]) |-> $past(evt[a])
        ) else $error("flag rose with no event");

        armed_clear_a: assert property (
            armed[a] && flag_wr0[a] && !evt[a] |=> !chan_flag[a]
        ) else $error("armed clear did not drop flag");

        edge_none_a: assert property (
            !center_aligned_pwm && mode[a] == MODE_CAPTURE
            && capture_edge_select[a] == EDGE_NONE |-> !evt[a]
        ) else $error("capture event with edge select off");

        cap_rise_a: assert property (
            !center_aligned_pwm && mode[a] == MODE_CAPTURE
            && capture_edge_select[a] == EDGE_RISE && !pin_prev_r[a] && pin_sync_r[a]
            |=> chan_flag[a] && chan_evt[a]
        ) else $error("rising capture missed");

        cap_fall_a: assert property (
            !center_aligned_pwm && mode[a] == MODE_CAPTURE
            && capture_edge_select[a] == EDGE_FALL && $fell(pin_sync_r[a])
            |=> chan_flag[a]
        ) else $error("falling capture missed");

        cmp_match_a: assert property (
            !center_aligned_pwm && mode[a] == MODE_COMPARE && cnt_step
            && cnt == chan_val[a] |=> chan_flag[a]
        ) else $error("compare match missed");

        epwm_match_a: assert property (
            !center_aligned_pwm && mode[a] == MODE_EDGE_PWM && cnt_step
            && cnt == chan_val[a] |=> chan_flag[a] && chan_evt[a]
        ) else $error("edge pwm match missed");

        center_aligned_pwm_match_a: assert property (
            center_aligned_pwm && cnt_step && cnt == chan_val[a] |=> chan_evt[a]
        ) else $error("center pwm match missed");

        cap_set_c: cover property (mode[a] == MODE_CAPTURE ##1 $rose(chan_flag[a]));
        center_aligned_pwm_twice_c: cover property (center_aligned_pwm && chan_evt[a]
            ##[1:1000] chan_evt[a] && center_aligned_pwm);
    end

    period_end_a: assert property (
        center_aligned_pwm && cnt_step && cnt_prev_r == modulus && cnt == mod_dn
        |=> period_end ##1 !period_end
    ) else $error("period end marker missed");

    period_mid_a: assert property (
        center_aligned_pwm && cnt_step && cnt == '0 |=> period_mid
    ) else $error("period midpoint marker missed");

    period_c: cover property (period_end ##[1:1000] period_mid);

endmodule

// File: inc/tcf_cfg.svh
`ifndef TCF_CFG_SVH
`define TCF_CFG_SVH

// ************************************************************
// widths and counts
// ************************************************************
`define TCF_CNT_W 16
`define TCF_NCH_DEF 2
`define TCF_NCH_MAX 8

// ************************************************************
// reset values
// ************************************************************
`define TCF_BIT_RST 1'b0
`define TCF_PULSE_LEN 1

`endif

// File: inc/tcf_pkg.sv
package tcf_pkg;

    typedef enum logic [1:0] {
        MODE_CAPTURE = 2'b00,
        MODE_COMPARE = 2'b01,
        MODE_EDGE_PWM = 2'b10,
        MODE_OFF = 2'b11
    } chan_mode_t;

    typedef enum logic [1:0] {
        EDGE_NONE = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_FALL = 2'b10,
        EDGE_BOTH = 2'b11
    } edge_sel_t;

endpackage

// File: tb/pin_src.sv
`timescale 1ns/10ps

// ************************************************************
// external pin driver, clocked from the timer clock with a fixed delay
// ************************************************************
module pin_src (
    input wire logic clk,
    input wire logic [1:0] want,
    output logic [1:0] pin
);
    initial pin = 2'b00;
    // moves a few ns after the edge, like an outside source would
    always @(posedge clk) begin
        pin <= #3 want;
    end
endmodule

// File: tb/tb.sv
`timescale 1ns/10ps

module tb;
    import tcf_pkg::*;

    logic clk, rstn, center_aligned_pwm, cnt_step, period_end, period_mid;
    logic [15:0] cnt, modulus;
    chan_mode_t [1:0] mode;
    edge_sel_t [1:0] esel;
    logic [1:0][15:0] chan_val;
    logic [1:0] pin_want, chan_pin, flag_rd, flag_wr0, chan_flag, chan_evt;
    int failures, samples_checked, n_evt, n_end, n_mid, n0, e0, m0;
    int n_evt1, n1;

    timer_channel_event_flags #(.NCH(2), .CNT_W(16)) u_dut (
        .clk(clk), .rstn(rstn), .center_aligned_pwm(center_aligned_pwm), .cnt(cnt),
        .cnt_step(cnt_step), .modulus(modulus), .mode(mode), .capture_edge_select(esel),
        .chan_val(chan_val), .chan_pin(chan_pin), .flag_rd(flag_rd), .flag_wr0(flag_wr0),
        .chan_flag(chan_flag), .chan_evt(chan_evt), .period_end(period_end),
        .period_mid(period_mid)
    );
    pin_src u_pins (.clk(clk), .want(pin_want), .pin(chan_pin));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // pulse counters see the value from before the edge's own updates land
    always @(posedge clk) begin
        if (chan_evt[0] === 1'b1) n_evt++;
        if (chan_evt[1] === 1'b1) n_evt1++;
        if (period_end === 1'b1) n_end++;
        if (period_mid === 1'b1) n_mid++;
    end

    // ************************************************************
    // helpers
    // ************************************************************
    task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (exp !== got) begin
            failures++;
            $display("BAD %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task step(input logic [15:0] c);
        @(posedge clk);
        cnt <= c;
        cnt_step <= 1'b1;
        @(posedge clk);
        cnt_step <= 1'b0;
    endtask

    task snap();
        @(negedge clk);
        n0 = n_evt;
        e0 = n_end;
        m0 = n_mid;
        n1 = n_evt1;
    endtask

    task clear_flag();
        @(posedge clk);
        flag_rd <= 2'b01;
        @(posedge clk);
        flag_rd <= 2'b00;
        flag_wr0 <= 2'b01;
        @(posedge clk);
        flag_wr0 <= 2'b00;
        @(negedge clk) chk("flag after clear", 16'h0000, 16'(chan_flag[0]));
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task capture_test();
        for (int e = 0; e < 4; e++) begin
            @(posedge clk);
            mode[0] <= MODE_CAPTURE;
            esel[0] <= edge_sel_t'(e);
            snap();
            pin_want[0] <= 1'b1;
            repeat (6) @(posedge clk);
            pin_want[0] <= 1'b0;
            repeat (6) @(posedge clk);
            @(negedge clk) chk("capture count", 16'(e[0]) + 16'(e[1]), 16'(n_evt - n0));
            chk("capture flag", 16'(e != 0), 16'(chan_flag[0]));
            chk("idle channel flag", 16'h0000, 16'(chan_flag[1]));
            clear_flag();
        end
    endtask

    task match_test(input chan_mode_t m, input int exp);
        @(posedge clk);
        mode[0] <= m;
        chan_val[0] <= 16'h0010;
        snap();
        step(16'h000f);
        step(16'h0010);
        repeat (4) @(posedge clk);
        step(16'h0011);
        step(16'h0010);
        @(posedge clk);
        @(negedge clk) chk("match count", 16'(exp), 16'(n_evt - n0));
        clear_flag();
    endtask

    task clear_test();
        match_test(MODE_COMPARE, 2);
        step(16'h0010);
        @(posedge clk);
        flag_wr0 <= 2'b01;
        @(posedge clk);
        flag_wr0 <= 2'b00;
        @(negedge clk) chk("flag bare write", 16'h0001, 16'(chan_flag[0]));
        @(posedge clk);
        flag_rd <= 2'b01;
        flag_wr0 <= 2'b01;
        @(posedge clk);
        flag_rd <= 2'b00;
        flag_wr0 <= 2'b00;
        @(negedge clk) chk("flag same cycle", 16'h0001, 16'(chan_flag[0]));
        clear_flag();
    endtask

    task center_test();
        logic [15:0] seq [9];
        seq = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0004,
                16'h0003, 16'h0002, 16'h0001, 16'h0000};
        @(posedge clk);
        center_aligned_pwm <= 1'b1;
        modulus <= 16'h0004;
        chan_val[0] <= 16'h0002;
        mode[0] <= MODE_OFF;
        snap();
        foreach (seq[i]) step(seq[i]);
        @(posedge clk);
        @(negedge clk) chk("center matches", 16'h0002, 16'(n_evt - n0));
        chk("period end", 16'h0001, 16'(n_end - e0));
        chk("period mid", 16'h0002, 16'(n_mid - m0));
        chk("center matches ch1", 16'h0002, 16'(n_evt1 - n1));
        chk("center flag ch1", 16'h0001, 16'(chan_flag[1]));
        clear_flag();
        @(posedge clk);
        center_aligned_pwm <= 1'b0;
        snap();
        step(16'h0004);
        step(16'h0003);
        step(16'h0000);
        @(posedge clk);
        @(negedge clk) chk("markers when off", 16'h0000, 16'(n_end - e0 + n_mid - m0));
    endtask

    task end_of_test();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        #200000;
        failures++;
        end_of_test();
    end

    initial begin
        rstn = 1'b0;
        center_aligned_pwm = 1'b0;
        cnt_step = 1'b0;
        cnt = 16'h0000;
        modulus = 16'h0004;
        mode[0] = MODE_OFF;
        mode[1] = MODE_OFF;
        esel[0] = EDGE_NONE;
        esel[1] = EDGE_NONE;
        chan_val = '0;
        pin_want = 2'b00;
        flag_rd = 2'b00;
        flag_wr0 = 2'b00;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        capture_test();
        match_test(MODE_EDGE_PWM, 2);
        match_test(MODE_OFF, 0);
        clear_test();
        center_test();
        end_of_test();
    end
endmodule
